// ### common/cfe_consts.svh
// Purpose: Field positions, codes and reset values for compare and extract
// Assumes: 32-bit instruction word, 32-bit data, 40-bit long operands
// Notes: Included by bare name; definitions only
`ifndef CFE_CONSTS_SVH
`define CFE_CONSTS_SVH

`define CFE_CREG_MSB 31
`define CFE_CREG_LSB 29
`define CFE_ZTEST_BIT 28
`define CFE_DEST_MSB 27
`define CFE_DEST_LSB 23
`define CFE_SECOND_MSB 22
`define CFE_SECOND_LSB 18
`define CFE_FIRST_MSB 17
`define CFE_FIRST_LSB 13
`define CFE_CROSS_BIT 12
`define CFE_OPF_MSB 11
`define CFE_OPF_LSB 5
`define CFE_SIDE_BIT 1
`define CFE_PAR_BIT 0

`define CFE_LCLASS_MSB 4
`define CFE_LCLASS_LSB 2
`define CFE_LCLASS_CODE 3'h6

`define CFE_OPF_LT_RR 7'h57
`define CFE_OPF_LT_CR 7'h56
`define CFE_OPF_LT_RL 7'h55
`define CFE_OPF_LT_CL 7'h54
`define CFE_OPF_LTU_RR 7'h5F
`define CFE_OPF_LTU_CR 7'h5E
`define CFE_OPF_LTU_RL 7'h5D
`define CFE_OPF_LTU_CL 7'h5C

`define CFE_RAMT_MSB 12
`define CFE_RAMT_LSB 8
`define CFE_XCONST_MSB 7
`define CFE_XCONST_LSB 2
`define CFE_EXT_CONST_CODE 6'h12
`define CFE_EXTU_CONST_CODE 6'h02
`define CFE_XREG_MSB 11
`define CFE_XREG_LSB 2
`define CFE_EXT_REG_CODE 10'h2F8
`define CFE_EXTU_REG_CODE 10'h2B8

`define CFE_SH_RIGHT_MSB 4
`define CFE_SH_RIGHT_LSB 0
`define CFE_SH_LEFT_MSB 9
`define CFE_SH_LEFT_LSB 5

`define CFE_CREG_ALWAYS 3'h0
`define CFE_RESULT_RST 32'h0000_0000
`define CFE_ADDR_RST 5'h00

`endif

// ### common/cfe_pkg.sv
// Purpose: Types and shared helpers for compare and extract datapath
// Assumes: Nothing beyond the constants header
// Notes: Used by scoped names only
`default_nettype none
package cfe_pkg;

  typedef enum logic [3:0] {
    CLS_NONE = 4'h0,
    CLS_LT_RR = 4'h1,
    CLS_LT_CR = 4'h2,
    CLS_LT_RL = 4'h3,
    CLS_LT_CL = 4'h4,
    CLS_LTU_RR = 4'h5,
    CLS_LTU_CR = 4'h6,
    CLS_LTU_RL = 4'h7,
    CLS_LTU_CL = 4'h8,
    CLS_EXT_C = 4'h9,
    CLS_EXTU_C = 4'hA,
    CLS_EXT_R = 4'hB,
    CLS_EXTU_R = 4'hC
  } insn_class_t;

  typedef enum logic [2:0] {
    UNIT_NONE = 3'h0,
    UNIT_LOGIC_A = 3'h1,
    UNIT_LOGIC_B = 3'h2,
    UNIT_SHIFT_A = 3'h3,
    UNIT_SHIFT_B = 3'h4
  } unit_t;

  // Widen a 32-bit value to 40 bits with sign or zero fill
  function automatic logic [39:0] widen_40(input logic [31:0] v, input logic sgn);
    widen_40 = {{8{sgn & v[31]}}, v};
  endfunction

endpackage
`default_nettype wire

// ### common/operand_bus_if.sv
// Purpose: Operand and result carrier between the core and its two units
// Assumes: Single clock domain, purely combinational traffic
// Notes: One modport per party
`timescale 1ns/1ps
`default_nettype none
interface operand_bus_if;
  logic [39:0] first_val;
  logic [39:0] second_val;
  logic is_signed;
  logic [4:0] left_amt;
  logic [4:0] right_amt;
  logic less_flag;
  logic [31:0] extract_val;

  modport core (output first_val, second_val, is_signed, left_amt, right_amt,
                input less_flag, extract_val);
  modport cmp (input first_val, second_val, is_signed, output less_flag);
  modport ext (input second_val, is_signed, left_amt, right_amt, output extract_val);
endinterface
`default_nettype wire

// ### rtl/less_compare_unit.sv
// Purpose: 40-bit less-than comparator, signed or unsigned
// Assumes: Operands already widened to 40 bits
// Notes: Combinational
`timescale 1ns/1ps
`default_nettype none
module less_compare_unit (
  operand_bus_if.cmp bus
);
  always_comb
  begin
    if (bus.is_signed)
      bus.less_flag = $signed(bus.first_val) < $signed(bus.second_val);
    else
      bus.less_flag = bus.first_val < bus.second_val;
  end
endmodule
`default_nettype wire

// ### rtl/field_extract_unit.sv
// Purpose: Bit-field extract by left shift then right shift
// Assumes: Field lives in the low 32 bits of second_val
// Notes: Combinational
`timescale 1ns/1ps
`default_nettype none
module field_extract_unit (
  operand_bus_if.ext bus
);
  logic [31:0] shifted_left;

  always_comb
  begin
    shifted_left = bus.second_val[31:0] << bus.left_amt;
    if (bus.is_signed)
      bus.extract_val = $unsigned($signed(shifted_left) >>> bus.right_amt);
    else
      bus.extract_val = shifted_left >> bus.right_amt;
  end
endmodule
`default_nettype wire

// ### rtl/compare_and_field_extract.sv
// Purpose: Less-than compare and bit-field extract execute slice
// Assumes: Register files answer read addresses in the same cycle
// Notes: Result is registered at the end of the single execute cycle
`timescale 1ns/1ps
`default_nettype none
`include "cfe_consts.svh"

module compare_and_field_extract (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic instr_valid,
  input wire logic [31:0] instr_word,
  input wire logic [31:0] first_data,
  input wire logic [31:0] second_data,
  input wire logic [7:0] second_hi_data,
  input wire logic [31:0] cross_data,
  input wire logic [31:0] cond_value,
  output logic [4:0] first_addr,
  output logic [4:0] second_addr,
  output logic [4:0] cross_addr,
  output logic cross_active,
  output logic [2:0] cond_sel,
  output logic result_we,
  output logic [31:0] result_data,
  output logic [4:0] result_addr,
  output logic result_side,
  output logic result_parallel,
  output logic [2:0] result_unit,
  output logic unsupported
);

  operand_bus_if bus ();

  cfe_pkg::insn_class_t insn_class;
  logic [2:0] creg_field;
  logic ztest_bit;
  logic [4:0] dest_field;
  logic [4:0] second_field;
  logic [4:0] first_field;
  logic cross_bit;
  logic [6:0] opf_field;
  logic side_bit;
  logic par_bit;
  logic [2:0] lclass_field;
  logic [5:0] xconst_field;
  logic [9:0] xreg_field;
  logic [4:0] ramt_field;
  logic is_compare;
  logic is_extract;
  logic pred_true;
  logic [31:0] first_word;
  logic [31:0] signed_5bit_constant_word;
  logic [31:0] unsigned_4bit_constant_word;
  logic [31:0] second_word;
  logic [31:0] result_next;
  cfe_pkg::unit_t unit_next;
  logic result_we_reg;
  logic [31:0] result_data_reg;
  logic [4:0] result_addr_reg;
  logic result_side_reg;
  logic result_parallel_reg;
  cfe_pkg::unit_t result_unit_reg;
  logic unsupported_reg;

  // Field split of the instruction word
  always_comb
  begin
    creg_field = instr_word[`CFE_CREG_MSB:`CFE_CREG_LSB];
    ztest_bit = instr_word[`CFE_ZTEST_BIT];
    dest_field = instr_word[`CFE_DEST_MSB:`CFE_DEST_LSB];
    second_field = instr_word[`CFE_SECOND_MSB:`CFE_SECOND_LSB];
    first_field = instr_word[`CFE_FIRST_MSB:`CFE_FIRST_LSB];
    cross_bit = instr_word[`CFE_CROSS_BIT];
    opf_field = instr_word[`CFE_OPF_MSB:`CFE_OPF_LSB];
    side_bit = instr_word[`CFE_SIDE_BIT];
    par_bit = instr_word[`CFE_PAR_BIT];
    lclass_field = instr_word[`CFE_LCLASS_MSB:`CFE_LCLASS_LSB];
    xconst_field = instr_word[`CFE_XCONST_MSB:`CFE_XCONST_LSB];
    xreg_field = instr_word[`CFE_XREG_MSB:`CFE_XREG_LSB];
    ramt_field = instr_word[`CFE_RAMT_MSB:`CFE_RAMT_LSB];
  end

  // Operation decode
  always_comb
  begin
    insn_class = cfe_pkg::CLS_NONE;
    if (lclass_field == `CFE_LCLASS_CODE)
    begin
      case (opf_field)
        `CFE_OPF_LT_RR: insn_class = cfe_pkg::CLS_LT_RR;
        `CFE_OPF_LT_CR: insn_class = cfe_pkg::CLS_LT_CR;
        `CFE_OPF_LT_RL: insn_class = cfe_pkg::CLS_LT_RL;
        `CFE_OPF_LT_CL: insn_class = cfe_pkg::CLS_LT_CL;
        `CFE_OPF_LTU_RR: insn_class = cfe_pkg::CLS_LTU_RR;
        `CFE_OPF_LTU_CR: insn_class = cfe_pkg::CLS_LTU_CR;
        `CFE_OPF_LTU_RL: insn_class = cfe_pkg::CLS_LTU_RL;
        `CFE_OPF_LTU_CL: insn_class = cfe_pkg::CLS_LTU_CL;
        default: insn_class = cfe_pkg::CLS_NONE;
      endcase
    end
    else if (xreg_field == `CFE_EXT_REG_CODE)
      insn_class = cfe_pkg::CLS_EXT_R;
    else if (xreg_field == `CFE_EXTU_REG_CODE)
      insn_class = cfe_pkg::CLS_EXTU_R;
    else if (xconst_field == `CFE_EXT_CONST_CODE)
      insn_class = cfe_pkg::CLS_EXT_C;
    else if (xconst_field == `CFE_EXTU_CONST_CODE)
      insn_class = cfe_pkg::CLS_EXTU_C;
  end

  // Unit steering: compares to logic units, extracts to shift units
  always_comb
  begin
    is_compare = 1'b0;
    is_extract = 1'b0;
    case (insn_class)
      cfe_pkg::CLS_LT_RR,
      cfe_pkg::CLS_LT_CR,
      cfe_pkg::CLS_LT_RL,
      cfe_pkg::CLS_LT_CL,
      cfe_pkg::CLS_LTU_RR,
      cfe_pkg::CLS_LTU_CR,
      cfe_pkg::CLS_LTU_RL,
      cfe_pkg::CLS_LTU_CL: is_compare = 1'b1;
      cfe_pkg::CLS_EXT_C,
      cfe_pkg::CLS_EXTU_C,
      cfe_pkg::CLS_EXT_R,
      cfe_pkg::CLS_EXTU_R: is_extract = 1'b1;
      default:
      begin
        is_compare = 1'b0;
        is_extract = 1'b0;
      end
    endcase
    if (is_compare)
      unit_next = side_bit ? cfe_pkg::UNIT_LOGIC_B : cfe_pkg::UNIT_LOGIC_A;
    else if (is_extract)
      unit_next = side_bit ? cfe_pkg::UNIT_SHIFT_B : cfe_pkg::UNIT_SHIFT_A;
    else
      unit_next = cfe_pkg::UNIT_NONE;
  end

  // Predicate evaluation
  always_comb
  begin
    if (creg_field == `CFE_CREG_ALWAYS)
      pred_true = 1'b1;
    else if (ztest_bit)
      pred_true = (cond_value == `CFE_RESULT_RST);
    else
      pred_true = (cond_value != `CFE_RESULT_RST);
  end

  // Register file read ports and cross path choice
  always_comb
  begin
    first_addr = first_field;
    second_addr = second_field;
    cond_sel = creg_field;
    cross_active = 1'b0;
    cross_addr = `CFE_ADDR_RST;
    if (instr_valid && cross_bit)
    begin
      case (insn_class)
        cfe_pkg::CLS_LT_RR,
        cfe_pkg::CLS_LT_CR,
        cfe_pkg::CLS_LTU_RR,
        cfe_pkg::CLS_LTU_CR,
        cfe_pkg::CLS_EXT_R,
        cfe_pkg::CLS_EXTU_R:
        begin
          cross_active = 1'b1;
          cross_addr = second_field;
        end
        cfe_pkg::CLS_LT_RL,
        cfe_pkg::CLS_LTU_RL:
        begin
          cross_active = 1'b1;
          cross_addr = first_field;
        end
        default:
        begin
          cross_active = 1'b0;
          cross_addr = `CFE_ADDR_RST;
        end
      endcase
    end
  end

  // Operand formation
  always_comb
  begin
    signed_5bit_constant_word = {{27{first_field[4]}}, first_field};
    unsigned_4bit_constant_word = {28'h000_0000, first_field[3:0]};
    first_word = first_data;
    second_word = second_data;
    case (insn_class)
      cfe_pkg::CLS_LT_RR,
      cfe_pkg::CLS_LTU_RR,
      cfe_pkg::CLS_EXT_R,
      cfe_pkg::CLS_EXTU_R:
      begin
        first_word = first_data;
        second_word = cross_bit ? cross_data : second_data;
      end
      cfe_pkg::CLS_LT_CR:
      begin
        first_word = signed_5bit_constant_word;
        second_word = cross_bit ? cross_data : second_data;
      end
      cfe_pkg::CLS_LTU_CR:
      begin
        first_word = unsigned_4bit_constant_word;
        second_word = cross_bit ? cross_data : second_data;
      end
      cfe_pkg::CLS_LT_RL,
      cfe_pkg::CLS_LTU_RL:
        first_word = cross_bit ? cross_data : first_data;
      cfe_pkg::CLS_LT_CL:
        first_word = signed_5bit_constant_word;
      cfe_pkg::CLS_LTU_CL:
        first_word = unsigned_4bit_constant_word;
      default:
      begin
        first_word = first_data;
        second_word = second_data;
      end
    endcase
  end

  // Drive the unit carrier
  always_comb
  begin
    bus.is_signed = 1'b0;
    case (insn_class)
      cfe_pkg::CLS_LT_RR,
      cfe_pkg::CLS_LT_CR,
      cfe_pkg::CLS_LT_RL,
      cfe_pkg::CLS_LT_CL,
      cfe_pkg::CLS_EXT_C,
      cfe_pkg::CLS_EXT_R: bus.is_signed = 1'b1;
      default: bus.is_signed = 1'b0;
    endcase
    bus.first_val = cfe_pkg::widen_40(first_word, bus.is_signed);
    if (insn_class == cfe_pkg::CLS_LT_RL || insn_class == cfe_pkg::CLS_LT_CL
        || insn_class == cfe_pkg::CLS_LTU_RL || insn_class == cfe_pkg::CLS_LTU_CL)
      bus.second_val = {second_hi_data, second_data};
    else
      bus.second_val = cfe_pkg::widen_40(second_word, bus.is_signed);
    if (insn_class == cfe_pkg::CLS_EXT_R || insn_class == cfe_pkg::CLS_EXTU_R)
    begin
      bus.left_amt = first_data[`CFE_SH_LEFT_MSB:`CFE_SH_LEFT_LSB];
      bus.right_amt = first_data[`CFE_SH_RIGHT_MSB:`CFE_SH_RIGHT_LSB];
    end
    else
    begin
      bus.left_amt = first_field;
      bus.right_amt = ramt_field;
    end
  end

  less_compare_unit u_cmp (
    .bus(bus.cmp)
  );

  field_extract_unit u_ext (
    .bus(bus.ext)
  );

  // Result selection
  always_comb
  begin
    if (is_compare)
      result_next = {31'h0000_0000, bus.less_flag};
    else
      result_next = bus.extract_val;
  end

  // Write port, single execute cycle
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      result_we_reg <= 1'b0;
      result_data_reg <= `CFE_RESULT_RST;
      result_addr_reg <= `CFE_ADDR_RST;
      result_side_reg <= 1'b0;
      result_parallel_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      result_we_reg <= instr_valid && pred_true && (is_compare || is_extract);
      if (instr_valid && pred_true && (is_compare || is_extract))
      begin
        result_data_reg <= result_next;
        result_addr_reg <= dest_field;
        result_side_reg <= side_bit;
        result_parallel_reg <= par_bit;
      end
    end
  end

  // Unit tag and unsupported code flag
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      result_unit_reg <= cfe_pkg::UNIT_NONE;
      unsupported_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      result_unit_reg <= instr_valid ? unit_next : cfe_pkg::UNIT_NONE;
      unsupported_reg <= instr_valid && !(is_compare || is_extract);
    end
  end

  assign result_we = result_we_reg;
  assign result_data = result_data_reg;
  assign result_addr = result_addr_reg;
  assign result_side = result_side_reg;
  assign result_parallel = result_parallel_reg;
  assign result_unit = result_unit_reg;
  assign unsupported = unsupported_reg;

endmodule
`default_nettype wire

// ### testbench/cfe_checker_assertions.sv
// Purpose: Port-level checks of the compare and field extract slice
// Assumes: One clock, synchronous active-low reset
// Notes: Bound to the top module below
`timescale 1ns/1ps
`default_nettype none
module cfe_checker (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic instr_valid,
  input wire logic [31:0] instr_word,
  input wire logic [31:0] second_data,
  input wire logic [31:0] cond_value,
  input wire logic [4:0] first_addr,
  input wire logic [4:0] second_addr,
  input wire logic cross_active,
  input wire logic [2:0] cond_sel,
  input wire logic result_we,
  input wire logic [31:0] result_data,
  input wire logic [2:0] result_unit,
  input wire logic unsupported
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);
  logic go;
  logic pfalse;
  logic cmp_op;
  assign go = clk_en && instr_valid;
  assign pfalse = instr_word[31:29] != 3'h0 && (instr_word[28] == (cond_value != 32'h0));
  assign cmp_op = instr_word[4:2] == 3'h6 && instr_word[11:9] == 3'h5 && instr_word[7];
  chk_field_decode: assert property (first_addr == instr_word[17:13] &&
    second_addr == instr_word[22:18] && cond_sel == instr_word[31:29])
    else $error("operand address fields wrong");
  chk_cross_second: assert property (go && instr_word[4:2] == 3'h6 &&
    instr_word[11:5] == 7'h57 |-> cross_active == instr_word[12])
    else $error("cross select wrong");
  chk_idle_quiet: assert property (clk_en && !instr_valid |=> !result_we && $stable(result_data))
    else $error("write without instruction");
  chk_cmp_result: assert property (go && !pfalse && cmp_op && !instr_word[1] |=>
    result_we && result_unit == 3'h1 && result_data[31:1] == 31'h0)
    else $error("compare result or unit wrong");
  chk_ext_unit: assert property (go && !pfalse && instr_word[7:2] == 6'h12 && instr_word[1] |=>
    result_we && result_unit == 3'h4)
    else $error("extract unit wrong");
  chk_pred_hold: assert property (go && pfalse |=> !result_we && $stable(result_data))
    else $error("false predicate wrote");
  chk_unknown_code: assert property (go && instr_word[4:2] == 3'h7 |=> unsupported && !result_we)
    else $error("unknown code not flagged");
  chk_extu_zero: assert property (go && !pfalse && instr_word[7:2] == 6'h02 &&
    instr_word[12:8] != 5'h00 |=> result_data[31] == 1'b0)
    else $error("unsigned extract not zero filled");
  chk_ext_copy: assert property (go && !pfalse && instr_word[7:2] == 6'h12 &&
    instr_word[17:8] == 10'h000 |=> result_data == $past(second_data))
    else $error("zero shift extract wrong");
endmodule
bind compare_and_field_extract cfe_checker cfe_checker_inst (.mclk(mclk), .rst_b(rst_b),
  .clk_en(clk_en), .instr_valid(instr_valid), .instr_word(instr_word),
  .second_data(second_data), .cond_value(cond_value), .first_addr(first_addr),
  .second_addr(second_addr), .cross_active(cross_active), .cond_sel(cond_sel),
  .result_we(result_we), .result_data(result_data), .result_unit(result_unit),
  .unsupported(unsupported));
`default_nettype wire

// ### testbench/reg_file_model.sv
// Purpose: Register files and predicate registers feeding the slice
// Assumes: Contents loaded by the testbench before use
// Notes: Same-cycle combinational reads
`timescale 1ns/1ps
`default_nettype none
module reg_file_model (
  input wire logic [4:0] first_addr,
  input wire logic [4:0] second_addr,
  input wire logic [4:0] cross_addr,
  input wire logic [2:0] cond_sel,
  output logic [31:0] first_data,
  output logic [31:0] second_data,
  output logic [7:0] second_hi_data,
  output logic [31:0] cross_data,
  output logic [31:0] cond_value
);
  logic [31:0] near_file [32];
  logic [31:0] far_file [32];
  logic [7:0] high_file [32];
  logic [31:0] pred_file [8];
  // Operands answered in the same cycle as the address
  assign first_data = near_file[first_addr];
  assign second_data = near_file[second_addr];
  assign second_hi_data = high_file[second_addr];
  assign cross_data = far_file[cross_addr];
  assign cond_value = pred_file[cond_sel];
endmodule
`default_nettype wire

// ### testbench/compare_and_field_extract_tb.sv
// Purpose: Self-checking bench for compare and field extract
// Assumes: One-cycle result latency, clk_en held high except while the enable_hold task drops it
// Notes: Register contents set directly in the file model
`timescale 1ns/1ps
`default_nettype none
module compare_and_field_extract_tb;
  logic mclk, rst_b, clk_en, instr_valid;
  logic [31:0] instr_word, first_data, second_data, cross_data, cond_value, result_data;
  logic [7:0] second_hi_data;
  logic [4:0] first_addr, second_addr, cross_addr, result_addr;
  logic [2:0] cond_sel, result_unit;
  logic cross_active, result_we, result_side, result_parallel, unsupported;
  logic [31:0] last;
  int err_count;
  int total_checks;
  compare_and_field_extract compare_and_field_extract_inst (.mclk(mclk), .rst_b(rst_b),
    .clk_en(clk_en), .instr_valid(instr_valid), .instr_word(instr_word),
    .first_data(first_data), .second_data(second_data), .second_hi_data(second_hi_data),
    .cross_data(cross_data), .cond_value(cond_value), .first_addr(first_addr),
    .second_addr(second_addr), .cross_addr(cross_addr), .cross_active(cross_active),
    .cond_sel(cond_sel), .result_we(result_we), .result_data(result_data),
    .result_addr(result_addr), .result_side(result_side), .result_parallel(result_parallel),
    .result_unit(result_unit), .unsupported(unsupported));
  reg_file_model reg_file_model_inst (.first_addr(first_addr), .second_addr(second_addr),
    .cross_addr(cross_addr), .cond_sel(cond_sel), .first_data(first_data),
    .second_data(second_data), .second_hi_data(second_hi_data), .cross_data(cross_data),
    .cond_value(cond_value));
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  function automatic logic [31:0] cmp(input logic [6:0] opf, input logic [4:0] s1,
    input logic [4:0] s2, input logic x);
    cmp = {4'h0, 5'h07, s2, s1, x, opf, 3'h6, 2'h0};
  endfunction
  function automatic logic [31:0] xc(input logic [4:0] l, input logic [4:0] r, input logic sg);
    xc = {4'h0, 5'h07, 5'h08, l, r, sg ? 6'h12 : 6'h02, 2'h2};
  endfunction
  function automatic logic [31:0] xr(input logic [4:0] s1, input logic [4:0] s2,
    input logic x, input logic sg);
    xr = {4'h0, 5'h07, s2, s1, x, sg ? 10'h2F8 : 10'h2B8, 2'h2};
  endfunction
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic exec(input logic [31:0] w, input logic we, input logic [31:0] d,
    input logic [2:0] u);
    @(posedge mclk);
    instr_valid <= 1'b1;
    instr_word <= w;
    @(posedge mclk);
    instr_valid <= 1'b0;
    #1;
    check("write", {31'h0, we}, {31'h0, result_we});
    check("data", d, result_data);
    if (u != 3'h7)
      check("unit", {29'h0, u}, {29'h0, result_unit});
    if (we)
    begin
      check("addr", {27'h0, w[27:23]}, {27'h0, result_addr});
      check("side", {31'h0, w[1]}, {31'h0, result_side});
      check("parallel", {31'h0, w[0]}, {31'h0, result_parallel});
    end
    last = d;
  endtask
  task automatic signed_cmp;
    exec(cmp(7'h57, 5'h01, 5'h02, 1'b0), 1'b1, 32'h1, 3'h1);
    exec(cmp(7'h57, 5'h02, 5'h01, 1'b0), 1'b1, 32'h0, 3'h1);
    exec(cmp(7'h57, 5'h01, 5'h02, 1'b1), 1'b1, 32'h0, 3'h1);
    exec(cmp(7'h56, 5'h1F, 5'h05, 1'b0), 1'b1, 32'h1, 3'h1);
    exec(cmp(7'h56, 5'h09, 5'h05, 1'b0), 1'b1, 32'h0, 3'h1);
    exec(cmp(7'h55, 5'h01, 5'h03, 1'b0), 1'b1, 32'h0, 3'h1);
    exec(cmp(7'h55, 5'h02, 5'h05, 1'b1), 1'b1, 32'h1, 3'h1);
    exec(cmp(7'h54, 5'h1F, 5'h05, 1'b0), 1'b1, 32'h1, 3'h1);
    $display("signed compare done");
  endtask
  task automatic unsigned_cmp;
    exec(cmp(7'h5F, 5'h01, 5'h02, 1'b0), 1'b1, 32'h0, 3'h1);
    exec(cmp(7'h5F, 5'h02, 5'h01, 1'b0), 1'b1, 32'h1, 3'h1);
    exec(cmp(7'h5F, 5'h02, 5'h02, 1'b1), 1'b1, 32'h1, 3'h1);
    exec(cmp(7'h5E, 5'h0E, 5'h03, 1'b0), 1'b1, 32'h1, 3'h1);
    exec(cmp(7'h5E, 5'h0E, 5'h05, 1'b0), 1'b1, 32'h0, 3'h1);
    exec(cmp(7'h5D, 5'h02, 5'h03, 1'b0), 1'b1, 32'h1, 3'h1);
    exec(cmp(7'h5C, 5'h0E, 5'h05, 1'b0), 1'b1, 32'h0, 3'h1);
    $display("unsigned compare done");
  endtask
  task automatic extract_const;
    exec(xc(5'h0A, 5'h13, 1'b1), 1'b1, 32'hFFFF_F21F, 3'h4);
    exec(xc(5'h0A, 5'h13, 1'b0), 1'b1, 32'h0000_121F, 3'h4);
    exec(xc(5'h00, 5'h00, 1'b1) & 32'hFFFF_FFFD, 1'b1, 32'h07A4_3F2A, 3'h3);
    exec(xc(5'h10, 5'h18, 1'b0), 1'b1, 32'h0000_003F, 3'h4);
    $display("constant extract done");
  endtask
  task automatic extract_reg;
    exec(xr(5'h03, 5'h09, 1'b0, 1'b1), 1'b1, 32'h0000_03B6, 3'h4);
    exec(xr(5'h04, 5'h09, 1'b0, 1'b0), 1'b1, 32'h0000_036E, 3'h4);
    exec(xr(5'h03, 5'h0A, 1'b1, 1'b1), 1'b1, 32'h0000_03B6, 3'h4);
    $display("register extract done");
  endtask
  task automatic predicate_and_code;
    exec(cmp(7'h57, 5'h01, 5'h02, 1'b0) | 32'h2000_0000, 1'b0, last, 3'h1);
    exec(cmp(7'h57, 5'h01, 5'h02, 1'b0) | 32'h3000_0001, 1'b1, 32'h1, 3'h1);
    exec(xc(5'h0A, 5'h13, 1'b1) | 32'h5000_0000, 1'b0, last, 3'h4);
    exec(32'h0000_001C, 1'b0, last, 3'h7);
    check("flag", 32'h1, {31'h0, unsupported});
    $display("predicate and code done");
  endtask
  task automatic enable_hold;
    @(posedge mclk);
    clk_en <= 1'b0;
    instr_valid <= 1'b1;
    instr_word <= cmp(7'h57, 5'h02, 5'h01, 1'b0) | 32'h0000_0002;
    repeat (2) @(posedge mclk);
    #1;
    check("frozen write", 32'h0, {31'h0, result_we});
    check("frozen data", last, result_data);
    @(posedge mclk);
    clk_en <= 1'b1;
    @(posedge mclk);
    instr_valid <= 1'b0;
    #1;
    check("enabled write", 32'h1, {31'h0, result_we});
    check("enabled data", 32'h0, result_data);
    check("enabled unit", 32'h2, {29'h0, result_unit});
    $display("clock enable done");
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (5000) @(posedge mclk);
    err_count++;
    end_of_test();
  end
  initial
  begin
    rst_b = 1'b0;
    clk_en = 1'b1;
    instr_valid = 1'b0;
    instr_word = 32'h0;
    err_count = 0;
    total_checks = 0;
    for (int i = 0; i < 32; i++)
    begin
      reg_file_model_inst.near_file[i] = ~(i * 32'h0101_0101);
      reg_file_model_inst.far_file[i] = i * 32'h0102_0304;
      reg_file_model_inst.high_file[i] = 8'h00;
      if (i < 8)
        reg_file_model_inst.pred_file[i] = 32'h1;
    end
    reg_file_model_inst.near_file[1] = 32'hFFFF_FED6;
    reg_file_model_inst.near_file[2] = 32'h0000_000C;
    reg_file_model_inst.near_file[3] = 32'h0000_0073;
    reg_file_model_inst.near_file[4] = 32'h0000_0156;
    reg_file_model_inst.near_file[5] = 32'h0000_0005;
    reg_file_model_inst.near_file[8] = 32'h07A4_3F2A;
    reg_file_model_inst.near_file[9] = 32'h03B6_E7D5;
    reg_file_model_inst.near_file[10] = 32'h0000_0000;
    reg_file_model_inst.far_file[10] = 32'h03B6_E7D5;
    reg_file_model_inst.far_file[2] = 32'h8000_0000;
    reg_file_model_inst.high_file[3] = 8'h80;
    reg_file_model_inst.pred_file[1] = 32'h0;
    repeat (4) @(posedge mclk);
    rst_b <= 1'b1;
    signed_cmp();
    unsigned_cmp();
    extract_const();
    extract_reg();
    predicate_and_code();
    enable_hold();
    end_of_test();
  end
endmodule
`default_nettype wire
